// [src/cpc_config.sv]
`default_nettype none
// Contract
// - Idle-suspend bit set halts the counter array while the processor idles.
// - Timebase field selects one of seven counter increment sources; code 111 reserved.
// - Counter overflow interrupt requested only when its enable bit is one.
// - Reload-select bit steers capture/compare byte accesses to auto-reload registers.
// - Auto-reload values apply only to channels in 9 to 11-bit PWM; reload_apply also sets for reserved length codes 100 to 111.
// - Cycle overflow enable lets the cycle overflow flag raise an interrupt.
// - Cycle overflow flag sets on overflow out of the selected cycle bit.
// - Cycle overflow flag set by hardware or software, cleared only by software.
// - Cycle length field selects 8, 9, 10 or 11 bits; 100 to 111 reserved.
// - One cycle length serves all non-16-bit PWM channels; 16-bit ignores it.
// - Clear polarity picks falling (0) or rising (1) comparator transition.
// - Each channel has its own comparator clear enable bit 0, 1, 2.
// - Channel 0 mode register holds eight read/write mode bits resetting to zero.
// - Counter overflow flag sets on wrap from maximum to zero, held until cleared.
// - Triggering transition forces enabled PWM channel output low for the cycle.
// - Wide PWM select picks 16-bit PWM, effective only with PWM enabled.
module cpc_config (
  input wire logic clk,
  input wire logic sys_rst,
  input wire cpc_pkg::cpc_sfr_req_t sfr_req,
  output logic [7:0] sfr_rdata,
  input wire logic idle_mode,
  input wire logic counter_run,
  input wire logic timer0_overflow,
  input wire logic external_count_input,
  input wire logic ext_clock_in,
  input wire logic lfo_clock_in,
  input wire logic comparator_in,
  input wire logic counter_flag_clear,
  input wire cpc_pkg::cpc_chmode_t ch1_mode,
  input wire cpc_pkg::cpc_chmode_t ch2_mode,
  output logic [15:0] main_counter,
  output logic counter_overflow_flag,
  output logic reload_access_select,
  output logic [2:0] reload_apply,
  output logic [2:0] wide_pwm_active,
  output logic [2:0] channel_clear,
  output cpc_pkg::cpc_chmode_t channel0_mode,
  output logic irq_request
);
  import cpc_pkg::*;

  logic [7:0] counter_mode_config, next_counter_mode_config;
  logic [7:0] pwm_cycle_config, next_pwm_cycle_config;
  logic [7:0] comparator_clear_ctrl, next_comparator_clear_ctrl;
  cpc_chmode_t next_channel0_mode;
  logic [7:0] next_sfr_rdata;
  logic [15:0] next_main_counter;
  logic next_counter_overflow_flag;
  logic [2:0] next_channel_clear;
  logic [3:0] sync_meta, sync_out;
  logic cmp_prev;
  logic tick, advance, wrap, cycle_wrap, trigger, level_active;
  logic [15:0] len_mask;
  logic [2:0] timebase_select;
  logic [2:0] cycle_length_select;
  logic idle_suspend, overflow_irq_enable, cycle_overflow_irq_enable, cycle_overflow_flag, clear_polarity;
  cpc_chmode_t ch_mode [CPC_CHANNELS];

  // ==========================================================
  // Input synchronisers, two flops per asynchronous pin
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync_meta <= '0;
      sync_out <= '0;
      cmp_prev <= 1'b0;
    end else begin
      sync_meta <= {comparator_in, lfo_clock_in, ext_clock_in, external_count_input};
      sync_out <= sync_meta;
      cmp_prev <= sync_out[3];
    end
  end

  // ==========================================================
  // Field views
  assign idle_suspend = counter_mode_config[CPC_MD_IDLE_BIT];
  assign timebase_select = counter_mode_config[CPC_MD_TB_MSB:CPC_MD_TB_LSB];
  assign overflow_irq_enable = counter_mode_config[CPC_MD_OVF_IE_BIT];
  assign reload_access_select = pwm_cycle_config[CPC_PW_RELOAD_BIT];
  assign cycle_overflow_irq_enable = pwm_cycle_config[CPC_PW_COV_IE_BIT];
  assign cycle_overflow_flag = pwm_cycle_config[CPC_PW_CYCLE_OVERFLOW_FLAG_BIT];
  assign cycle_length_select = pwm_cycle_config[CPC_PW_LEN_MSB:CPC_PW_LEN_LSB];
  assign clear_polarity = comparator_clear_ctrl[CPC_CL_POL_BIT];
  assign ch_mode[0] = channel0_mode;
  assign ch_mode[1] = ch1_mode;
  assign ch_mode[2] = ch2_mode;

  cpc_timebase u_timebase (
    .clk(clk),
    .sys_rst(sys_rst),
    .timebase_select(timebase_select),
    .timer0_overflow(timer0_overflow),
    .ext_count_sync(sync_out[0]),
    .ext_clock_sync(sync_out[1]),
    .lfo_clock_sync(sync_out[2]),
    .tick(tick)
  );

  // ==========================================================
  // Counter and cycle length decode
  // Reserved length codes fall back to 8 bits rather than stall
  always_comb begin
    case (cycle_length_select)
      CPC_LEN_9: len_mask = CPC_MASK_9;
      CPC_LEN_10: len_mask = CPC_MASK_10;
      CPC_LEN_11: len_mask = CPC_MASK_11;
      default: len_mask = CPC_MASK_8;
    endcase
  end

  assign advance = tick & counter_run & ~(idle_suspend & idle_mode);
  assign wrap = advance & (main_counter == CPC_COUNT_MAX);
  assign cycle_wrap = advance & ((main_counter & len_mask) == len_mask);

  always_comb begin
    next_main_counter = advance ? main_counter + 16'h0001 : main_counter;
    next_counter_overflow_flag = wrap | (counter_overflow_flag & ~counter_flag_clear);
  end

  // ==========================================================
  // Special-function register writes and reads
  // Reserved bits are not stored, so they always read as zero
  always_comb begin
    next_counter_mode_config = counter_mode_config;
    next_pwm_cycle_config = pwm_cycle_config;
    next_comparator_clear_ctrl = comparator_clear_ctrl;
    next_channel0_mode = channel0_mode;
    next_sfr_rdata = sfr_rdata;
    if (sfr_req.wr) begin
      if (sfr_req.addr == CPC_ADDR_MODE_CFG) begin
        next_counter_mode_config = sfr_req.wdata & CPC_MD_WRITABLE;
      end else if (sfr_req.addr == CPC_ADDR_PWM_CFG) begin
        next_pwm_cycle_config = sfr_req.wdata & CPC_PW_WRITABLE;
      end else if (sfr_req.addr == CPC_ADDR_CLEAR_CTRL) begin
        next_comparator_clear_ctrl = sfr_req.wdata & CPC_CL_WRITABLE;
      end else if (sfr_req.addr == CPC_ADDR_CH0_MODE) begin
        next_channel0_mode = sfr_req.wdata;
      end
    end
    // Hardware set wins over a software clear in the same cycle
    if (cycle_wrap) begin
      next_pwm_cycle_config[CPC_PW_CYCLE_OVERFLOW_FLAG_BIT] = 1'b1;
    end
    if (sfr_req.rd) begin
      if (sfr_req.addr == CPC_ADDR_MODE_CFG) begin
        next_sfr_rdata = counter_mode_config;
      end else if (sfr_req.addr == CPC_ADDR_PWM_CFG) begin
        next_sfr_rdata = pwm_cycle_config;
      end else if (sfr_req.addr == CPC_ADDR_CLEAR_CTRL) begin
        next_sfr_rdata = comparator_clear_ctrl;
      end else if (sfr_req.addr == CPC_ADDR_CH0_MODE) begin
        next_sfr_rdata = channel0_mode;
      end else begin
        next_sfr_rdata = CPC_RESET_BYTE;
      end
    end
  end

  // ==========================================================
  // Comparator clear per channel
  // A trigger sets the clear; each cycle end re-arms it from the level
  assign trigger = clear_polarity ? (~cmp_prev & sync_out[3]) : (cmp_prev & ~sync_out[3]);
  assign level_active = clear_polarity ? sync_out[3] : ~sync_out[3];

  genvar ch;
  generate
    for (ch = 0; ch < CPC_CHANNELS; ch++) begin : g_ch
      logic pwm_on, cycle_end;
      assign pwm_on = ch_mode[ch].pwm_enable;
      assign wide_pwm_active[ch] = pwm_on & ch_mode[ch].wide_pwm_select;
      assign reload_apply[ch] = pwm_on & ~ch_mode[ch].wide_pwm_select & (cycle_length_select != CPC_LEN_8);
      assign cycle_end = wide_pwm_active[ch] ? wrap : cycle_wrap;
      always_comb begin
        if (!(pwm_on && comparator_clear_ctrl[ch])) begin
          next_channel_clear[ch] = 1'b0;
        end else if (trigger) begin
          next_channel_clear[ch] = 1'b1;
        end else if (cycle_end) begin
          next_channel_clear[ch] = level_active;
        end else begin
          next_channel_clear[ch] = channel_clear[ch];
        end
      end
    end
  endgenerate

  // ==========================================================
  // State registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      counter_mode_config <= CPC_RESET_BYTE;
      pwm_cycle_config <= CPC_RESET_BYTE;
      comparator_clear_ctrl <= CPC_RESET_BYTE;
      channel0_mode <= CPC_RESET_BYTE;
      sfr_rdata <= CPC_RESET_BYTE;
      main_counter <= '0;
      counter_overflow_flag <= 1'b0;
      channel_clear <= '0;
    end else begin
      counter_mode_config <= next_counter_mode_config;
      pwm_cycle_config <= next_pwm_cycle_config;
      comparator_clear_ctrl <= next_comparator_clear_ctrl;
      channel0_mode <= next_channel0_mode;
      sfr_rdata <= next_sfr_rdata;
      main_counter <= next_main_counter;
      counter_overflow_flag <= next_counter_overflow_flag;
      channel_clear <= next_channel_clear;
    end
  end

  // Combined request, level while any enabled flag stands
  assign irq_request = (counter_overflow_flag & overflow_irq_enable)
                     | (cycle_overflow_flag & cycle_overflow_irq_enable);
endmodule
`default_nettype wire

// [src/cpc_pkg.sv]
`default_nettype none
package cpc_pkg;
  // ==========================================================
  // Register addresses on the core's special-function bus
  localparam logic [7:0] CPC_ADDR_CLEAR_CTRL = 8'h9c;
  localparam logic [7:0] CPC_ADDR_MODE_CFG = 8'hd9;
  localparam logic [7:0] CPC_ADDR_CH0_MODE = 8'hda;
  localparam logic [7:0] CPC_ADDR_PWM_CFG = 8'hf7;
  localparam logic [7:0] CPC_RESET_BYTE = 8'h00;
  // Writable bits per register; reserved bits are dropped on write
  localparam logic [7:0] CPC_MD_WRITABLE = 8'h8f;
  localparam logic [7:0] CPC_PW_WRITABLE = 8'he7;
  localparam logic [7:0] CPC_CL_WRITABLE = 8'h87;

  // ==========================================================
  // Field positions
  localparam int CPC_MD_IDLE_BIT = 7;
  localparam int CPC_MD_TB_LSB = 1;
  localparam int CPC_MD_TB_MSB = 3;
  localparam int CPC_MD_OVF_IE_BIT = 0;
  localparam int CPC_PW_RELOAD_BIT = 7;
  localparam int CPC_PW_COV_IE_BIT = 6;
  localparam int CPC_PW_CYCLE_OVERFLOW_FLAG_BIT = 5;
  localparam int CPC_PW_LEN_LSB = 0;
  localparam int CPC_PW_LEN_MSB = 2;
  localparam int CPC_CL_POL_BIT = 7;
  localparam int CPC_CHANNELS = 3;

  // ==========================================================
  // Timebase and cycle length codes
  localparam logic [2:0] CPC_TB_DIV12 = 3'h0;
  localparam logic [2:0] CPC_TB_DIV4 = 3'h1;
  localparam logic [2:0] CPC_TB_TIMER0 = 3'h2;
  localparam logic [2:0] CPC_TB_EXT_FALL = 3'h3;
  localparam logic [2:0] CPC_TB_SYSCLK = 3'h4;
  localparam logic [2:0] CPC_TB_EXTCLK8 = 3'h5;
  localparam logic [2:0] CPC_TB_LFO8 = 3'h6;
  localparam logic [3:0] CPC_DIV12_LAST = 4'hb;
  localparam logic [1:0] CPC_DIV4_LAST = 2'h3;
  localparam logic [2:0] CPC_DIV8_LAST = 3'h7;
  localparam logic [2:0] CPC_LEN_8 = 3'h0;
  localparam logic [2:0] CPC_LEN_9 = 3'h1;
  localparam logic [2:0] CPC_LEN_10 = 3'h2;
  localparam logic [2:0] CPC_LEN_11 = 3'h3;
  localparam logic [15:0] CPC_COUNT_MAX = 16'hffff;
  localparam logic [15:0] CPC_MASK_8 = 16'h00ff;
  localparam logic [15:0] CPC_MASK_9 = 16'h01ff;
  localparam logic [15:0] CPC_MASK_10 = 16'h03ff;
  localparam logic [15:0] CPC_MASK_11 = 16'h07ff;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cpc_sfr_req_t;

  typedef struct packed {
    logic wide_pwm_select;
    logic compare_enable;
    logic rising_capture_enable;
    logic falling_capture_enable;
    logic match_enable;
    logic toggle_enable;
    logic pwm_enable;
    logic capcomp_irq_enable;
  } cpc_chmode_t;
endpackage
`default_nettype wire

// [src/cpc_timebase.sv]
`default_nettype none
module cpc_timebase (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [2:0] timebase_select,
  input wire logic timer0_overflow,
  input wire logic ext_count_sync,
  input wire logic ext_clock_sync,
  input wire logic lfo_clock_sync,
  output logic tick
);
  import cpc_pkg::*;

  logic [3:0] div12, next_div12;
  logic [1:0] div4, next_div4;
  logic [2:0] ext_div, next_ext_div;
  logic [2:0] lfo_div, next_lfo_div;
  logic ext_count_prev, ext_clock_prev, lfo_clock_prev;
  logic ext_fall, ext_rise, lfo_rise;

  // ==========================================================
  // Prescalers
  // Edges are taken from already synchronised levels only
  assign ext_fall = ext_count_prev & ~ext_count_sync;
  assign ext_rise = ~ext_clock_prev & ext_clock_sync;
  assign lfo_rise = ~lfo_clock_prev & lfo_clock_sync;

  always_comb begin
    next_div12 = (div12 == CPC_DIV12_LAST) ? '0 : div12 + 4'h1;
    next_div4 = div4 + 2'h1;
    next_ext_div = ext_rise ? ext_div + 3'h1 : ext_div;
    next_lfo_div = lfo_rise ? lfo_div + 3'h1 : lfo_div;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      div12 <= '0;
      div4 <= '0;
      ext_div <= '0;
      lfo_div <= '0;
      ext_count_prev <= 1'b0;
      ext_clock_prev <= 1'b0;
      lfo_clock_prev <= 1'b0;
    end else begin
      div12 <= next_div12;
      div4 <= next_div4;
      ext_div <= next_ext_div;
      lfo_div <= next_lfo_div;
      ext_count_prev <= ext_count_sync;
      ext_clock_prev <= ext_clock_sync;
      lfo_clock_prev <= lfo_clock_sync;
    end
  end

  // ==========================================================
  // Source select; reserved code never counts
  always_comb begin
    case (timebase_select)
      CPC_TB_DIV12: tick = (div12 == CPC_DIV12_LAST);
      CPC_TB_DIV4: tick = (div4 == CPC_DIV4_LAST);
      CPC_TB_TIMER0: tick = timer0_overflow;
      CPC_TB_EXT_FALL: tick = ext_fall;
      CPC_TB_SYSCLK: tick = 1'b1;
      CPC_TB_EXTCLK8: tick = ext_rise & (ext_div == CPC_DIV8_LAST);
      CPC_TB_LFO8: tick = lfo_rise & (lfo_div == CPC_DIV8_LAST);
      default: tick = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

// [verification/cpc_config_properties.sv]
`default_nettype none
// ==========
// Port-level checks on the configuration block
module cpc_config_props (
  input wire logic clk,
  input wire logic sys_rst,
  input wire cpc_pkg::cpc_sfr_req_t sfr_req,
  input wire logic [7:0] sfr_rdata,
  input wire logic counter_run,
  input wire logic counter_flag_clear,
  input wire logic [15:0] main_counter,
  input wire logic counter_overflow_flag,
  input wire logic reload_access_select,
  input wire logic [2:0] wide_pwm_active,
  input wire logic [2:0] channel_clear,
  input wire cpc_pkg::cpc_chmode_t channel0_mode,
  input wire cpc_pkg::cpc_chmode_t ch1_mode,
  input wire cpc_pkg::cpc_chmode_t ch2_mode
);
  import cpc_pkg::*;
  // One clock domain, so clock and reset are shared
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  property p_rd_ch0;
    sfr_req.rd && !sfr_req.wr && sfr_req.addr == 8'hda |=> sfr_rdata == $past(channel0_mode);
  endproperty
  a_rd_ch0: assert property (p_rd_ch0) else $error("mode read data wrong");
  property p_wr_ch0;
    sfr_req.wr && sfr_req.addr == 8'hda |=> channel0_mode == $past(sfr_req.wdata);
  endproperty
  a_wr_ch0: assert property (p_wr_ch0) else $error("mode write lost");
  property p_sel;
    sfr_req.wr && sfr_req.addr == 8'hf7 |=> reload_access_select == $past(sfr_req.wdata[7]);
  endproperty
  a_sel: assert property (p_sel) else $error("reload select wrong");
  property p_wrap;
    main_counter == 16'hffff ##1 main_counter == 16'h0000 |-> ##[0:1] counter_overflow_flag;
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap flag missing");
  property p_sticky;
    counter_overflow_flag && !counter_flag_clear |=> counter_overflow_flag;
  endproperty
  a_sticky: assert property (p_sticky) else $error("overflow flag dropped");
  property p_inc;
    $changed(main_counter) |-> main_counter == $past(main_counter) + 16'h0001;
  endproperty
  a_inc: assert property (p_inc) else $error("counter step not one");
  property p_run;
    !counter_run |=> $stable(main_counter);
  endproperty
  a_run: assert property (p_run) else $error("counter moved while stopped");
  property p_wide;
    wide_pwm_active == {ch2_mode.pwm_enable && ch2_mode.wide_pwm_select,
      ch1_mode.pwm_enable && ch1_mode.wide_pwm_select, channel0_mode.pwm_enable && channel0_mode.wide_pwm_select};
  endproperty
  a_wide: assert property (p_wide) else $error("wide mode wrong");
  property p_clr_off;
    !channel0_mode.pwm_enable |=> !channel_clear[0];
  endproperty
  a_clr_off: assert property (p_clr_off) else $error("clear on idle channel");
endmodule

bind cpc_config cpc_config_props u_props (.clk, .sys_rst, .sfr_req, .sfr_rdata, .counter_run,
  .counter_flag_clear, .main_counter, .counter_overflow_flag, .reload_access_select,
  .wide_pwm_active, .channel_clear, .channel0_mode, .ch1_mode, .ch2_mode);
`default_nettype wire

// [verification/test_counter_array_pwm_config.sv]
`default_nettype none
module test_counter_array_pwm_config;
  timeunit 1ns;
  timeprecision 1ns;
  import cpc_pkg::*;
  // ==========
  // Stimulus and observed signals
  logic clk = 0, sys_rst = 1, idle_mode = 0, counter_run = 0, timer0_overflow = 0;
  logic external_count_input = 0, ext_clock_in = 0, lfo_clock_in = 0, comparator_in = 1;
  logic counter_flag_clear = 0, counter_overflow_flag, reload_access_select, irq_request;
  cpc_sfr_req_t sfr_req = '0;
  cpc_chmode_t ch1_mode = '0, ch2_mode = 8'h82, channel0_mode;
  logic [7:0] sfr_rdata;
  logic [15:0] main_counter;
  logic [2:0] reload_apply, wide_pwm_active, channel_clear;
  int failures = 0, compares = 0;
  localparam logic [7:0] AD [4] = '{8'h9c, 8'hd9, 8'hda, 8'hf7};
  localparam logic [7:0] MK [4] = '{8'h87, 8'h8f, 8'hff, 8'he7};
  // Expected ticks per timebase code over a 60-cycle window
  localparam int EX [8] = '{5, 15, 4, 8, 60, 1, 1, 0};

  cpc_config DUT (.clk, .sys_rst, .sfr_req, .sfr_rdata, .idle_mode, .counter_run, .timer0_overflow,
    .external_count_input, .ext_clock_in, .lfo_clock_in, .comparator_in, .counter_flag_clear,
    .ch1_mode, .ch2_mode, .main_counter, .counter_overflow_flag, .reload_access_select,
    .reload_apply, .wide_pwm_active, .channel_clear, .channel0_mode, .irq_request);

  // Clock of 50 ns period
  always #25 clk = ~clk;

  // ==========
  // Shared helpers
  task chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Strobes last one cycle; the gap cycle keeps back-to-back calls legal
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr_req = '{1'b1, 1'b0, a, d};
    @(negedge clk);
    sfr_req = '0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    sfr_req = '{1'b0, 1'b1, a, 8'h00};
    @(negedge clk);
    sfr_req = '0;
    chk(sfr_rdata, exp, "read data");
  endtask
  task test_done;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ==========
  // Scenarios
  task t_regs;
    for (int i = 0; i < 4; i++) begin
      rd(AD[i], 8'h00);
      wr(AD[i], MK[i]);
      rd(AD[i], MK[i]);
    end
    chk(irq_request, 1'b1, "irq");
    chk(reload_access_select, 1'b1, "reload select");
    chk(wide_pwm_active, 3'b101, "wide");
    chk(reload_apply, 3'b000, "reload");
    wr(8'hda, 8'h02);
    chk(channel0_mode, 8'h02, "channel0 mode");
    chk(reload_apply, 3'b001, "reload");
    wr(8'hf7, 8'h40);
    chk(irq_request, 1'b0, "irq");
    chk(reload_apply, 3'b000, "reload");
    wr(8'h55, 8'hff);
    rd(8'h55, 8'h00);
    for (int i = 0; i < 4; i++) wr(AD[i], 8'h00);
  endtask
  // Every source over 60 cycles; edges every 6 cycles stay under a quarter clock
  task t_tb;
    logic [15:0] c0;
    for (int k = 0; k < 8; k++) begin
      wr(8'hd9, 8'(k * 2));
      cyc(2);
      c0 = main_counter;
      for (int i = 0; i < 60; i++) begin
        @(negedge clk);
        timer0_overflow = (k == 2) && (i % 12 == 0) && (i < 48);
        external_count_input = (i < 48) && ((i / 3) % 2 == 1);
        ext_clock_in = external_count_input;
        lfo_clock_in = external_count_input;
      end
      chk(main_counter - c0, 16'(EX[k]), "ticks");
    end
    wr(8'hd9, 8'h88);
    idle_mode = 1;
    cyc(2);
    c0 = main_counter;
    cyc(20);
    chk(main_counter - c0, 16'h0000, "idle hold");
    wr(8'hd9, 8'h08);
    cyc(2);
    c0 = main_counter;
    cyc(20);
    chk(main_counter - c0, 16'h0014, "idle run");
    idle_mode = 0;
  endtask
  task t_len;
    for (int n = 0; n < 4; n++) begin
      for (int w = 0; w < 5000 && (main_counter & ((16'h0100 << n) - 16'h0001)) !== 16'h0010; w++) cyc(1);
      wr(8'hf7, 8'(n));
      cyc((256 << n) - 64);
      rd(8'hf7, 8'(n));
      cyc(128);
      rd(8'hf7, 8'h20 + 8'(n));
    end
    wr(8'hf7, 8'h00);
  endtask
  task t_ovf;
    for (int w = 0; w < 70000 && counter_overflow_flag !== 1'b1; w++) cyc(1);
    chk(main_counter < 16'h0010, 1'b1, "wrap point");
    chk(irq_request, 1'b0, "irq");
    wr(8'hd9, 8'h09);
    chk(irq_request, 1'b1, "irq");
    wr(8'hd9, 8'h08);
    chk(irq_request, 1'b0, "irq");
    counter_flag_clear = 1;
    cyc(1);
    counter_flag_clear = 0;
    cyc(1);
    chk(counter_overflow_flag, 1'b0, "flag clear");
  endtask
  task t_clr;
    wr(8'hda, 8'h02);
    wr(8'h9c, 8'h01);
    cyc(6);
    chk(channel_clear, 3'b000, "clear");
    comparator_in = 0;
    cyc(6);
    chk(channel_clear, 3'b001, "clear");
    comparator_in = 1;
    cyc(300);
    chk(channel_clear, 3'b000, "clear");
    comparator_in = 0;
    ch1_mode = 8'h02;
    wr(8'h9c, 8'h82);
    cyc(6);
    chk(channel_clear, 3'b000, "clear");
    comparator_in = 1;
    cyc(6);
    chk(channel_clear, 3'b010, "clear");
  endtask

  // Main sequence
  initial begin
    cyc(12);
    sys_rst = 0;
    counter_run = 1;
    t_regs();
    t_tb();
    t_len();
    t_ovf();
    t_clr();
    test_done();
  end
  // Watchdog well beyond the longest wait above
  initial begin
    #4950000;
    failures++;
    test_done();
  end
endmodule
`default_nettype wire
